/* include/lsu_pkg.sv */
// Constants and types shared by the load/store address unit and its load extender.
// Assumes a 32-bit core with sixteen general registers, register fifteen being the program counter.
`default_nettype none

package lsu_pkg;

	localparam int unsigned WORD_W    = 32;
	localparam int unsigned IMM_W     = 12;
	localparam int unsigned REG_IDX_W = 4;

	localparam logic [REG_IDX_W-1:0] PC_IDX        = 4'hF;
	localparam logic [IMM_W-1:0]     IMM_MAX_WIDE  = 12'hFFF;
	localparam logic [IMM_W-1:0]     IMM_MAX_INDEX = 12'h0FF;
	localparam logic [IMM_W-1:0]     IMM_MAX_PAIR  = 12'h3FC;
	localparam logic [WORD_W-1:0]    PAIR_STEP     = 32'h0000_0004;
	localparam logic [WORD_W-1:0]    BIT0_CLEAR    = 32'hFFFF_FFFE;

	typedef enum logic [1:0] {KIND_ADR, KIND_LOAD, KIND_STORE, KIND_NONE} xfer_kind_t;
	typedef enum logic [1:0] {SIZE_BYTE, SIZE_HALF, SIZE_WORD, SIZE_PAIR} xfer_size_t;
	typedef enum logic [1:0] {MODE_OFFSET, MODE_PRE, MODE_POST, MODE_REG} addr_mode_t;
	typedef enum logic [0:0] {ST_IDLE, ST_ACCESS} lsu_state_t;

	typedef struct packed {
		lsu_state_t              st;
		logic                    second;
		xfer_kind_t              kind;
		xfer_size_t              size;
		logic                    sgn;
		addr_mode_t              mode;
		logic [REG_IDX_W-1:0]    rt;
		logic [REG_IDX_W-1:0]    rt2;
		logic [REG_IDX_W-1:0]    rn;
		logic [WORD_W-1:0]       data2;
		logic [WORD_W-1:0]       wb_val;
		logic                    mem_req;
		logic                    mem_we;
		logic [WORD_W-1:0]       mem_addr;
		logic [3:0]              mem_be;
		logic [WORD_W-1:0]       mem_wdata;
		logic                    rf_we;
		logic [REG_IDX_W-1:0]    rf_waddr;
		logic [WORD_W-1:0]       rf_wdata;
		logic                    wb_we;
		logic [REG_IDX_W-1:0]    wb_addr;
		logic [WORD_W-1:0]       wb_data;
		logic                    br_valid;
		logic [WORD_W-1:0]       br_target;
		logic                    done;
		logic                    fault;
	} lsu_regs_t;

	localparam lsu_regs_t LSU_RESET = '0;

endpackage

`default_nettype wire

/* verilog/load_extend.sv */
// Picks the addressed byte or halfword lane out of a read word and widens it to 32 bits.
// Assumes the memory returns the whole aligned word that holds the addressed data.
`default_nettype none

module load_extend (
	input  wire logic [1:0]                 addr_lo,
	input  wire lsu_pkg::xfer_size_t        size,
	input  wire logic                       sgn,
	input  wire logic [lsu_pkg::WORD_W-1:0] rdata,
	output logic      [lsu_pkg::WORD_W-1:0] data
);

	logic [7:0]  byte_val;
	logic [15:0] half_val;

	always_comb begin
		byte_val = rdata[8*addr_lo +: 8];
		half_val = addr_lo[1] ? rdata[31:16] : rdata[15:0];
		case (size)
			lsu_pkg::SIZE_BYTE: data = sgn ? {{24{byte_val[7]}}, byte_val} : {24'h000000, byte_val};
			lsu_pkg::SIZE_HALF: data = sgn ? {{16{half_val[15]}}, half_val} : {16'h0000, half_val};
			default:            data = rdata;
		endcase
	end

endmodule

`default_nettype wire

/* verilog/load_store_address_unit.sv */
// Address generation, base write-back and load extension for single and paired loads and stores,
// plus program-counter-relative address formation.
// Assumes decoded operands arrive with a valid/ready handshake and memory answers with a one-cycle ack.
//
// Summary of operation
// - Address result is program counter plus signed immediate.
// - Address immediate spans minus to plus 4095.
// - Address forming never touches condition flags.
// - Unsigned narrow loads zero-extend; stores write selected lanes.
// - Signed byte and halfword exist for loads only.
// - Offset mode uses base plus immediate, no write-back.
// - Pre-index uses and writes back base plus immediate.
// - Post-index uses base, then writes back sum.
// - Single immediates: -255..4095 offset, -255..255 indexed.
// - Pair immediates: multiples of four within 1020.
// - Transfers move one register or a pair.
// - Word load to program counter branches, bit0 cleared.
// - Register offset adds offset shifted left 0..3.
// - Register offset: byte, halfword, word only.
// - No load or store changes condition flags.
// - Failed condition: no write, access, flags, exception.
`default_nettype none

module load_store_address_unit (
	input  wire logic                          sys_clk,
	input  wire logic                          rst_n,
	input  wire logic                          req_valid,
	output logic                               req_ready,
	input  wire lsu_pkg::xfer_kind_t           req_kind,
	input  wire lsu_pkg::xfer_size_t           req_size,
	input  wire logic                          req_signed,
	input  wire lsu_pkg::addr_mode_t           req_mode,
	input  wire logic                          req_add,
	input  wire logic [lsu_pkg::IMM_W-1:0]     req_imm,
	input  wire logic [1:0]                    req_shift,
	input  wire logic [lsu_pkg::WORD_W-1:0]    req_base,
	input  wire logic [lsu_pkg::WORD_W-1:0]    req_index,
	input  wire logic [lsu_pkg::WORD_W-1:0]    req_pc,
	input  wire logic                          req_cond_pass,
	input  wire logic [lsu_pkg::REG_IDX_W-1:0] req_rt,
	input  wire logic [lsu_pkg::REG_IDX_W-1:0] req_rt2,
	input  wire logic [lsu_pkg::REG_IDX_W-1:0] req_rn,
	input  wire logic [lsu_pkg::WORD_W-1:0]    req_st_data,
	input  wire logic [lsu_pkg::WORD_W-1:0]    req_st_data2,
	output logic                               mem_req,
	output logic                               mem_we,
	output logic      [lsu_pkg::WORD_W-1:0]    mem_addr,
	output logic      [3:0]                    mem_be,
	output logic      [lsu_pkg::WORD_W-1:0]    mem_wdata,
	input  wire logic [lsu_pkg::WORD_W-1:0]    mem_rdata,
	input  wire logic                          mem_ack,
	output logic                               rf_we,
	output logic      [lsu_pkg::REG_IDX_W-1:0] rf_waddr,
	output logic      [lsu_pkg::WORD_W-1:0]    rf_wdata,
	output logic                               wb_we,
	output logic      [lsu_pkg::REG_IDX_W-1:0] wb_addr,
	output logic      [lsu_pkg::WORD_W-1:0]    wb_data,
	output logic                               branch_valid,
	output logic      [lsu_pkg::WORD_W-1:0]    branch_target,
	output logic                               flags_we,
	output logic                               done,
	output logic                               fault
);

	lsu_pkg::lsu_regs_t           s_r;
	lsu_pkg::lsu_regs_t           s_nxt;
	logic [lsu_pkg::WORD_W-1:0]   ext_data;
	logic [lsu_pkg::WORD_W-1:0]   imm_sum;
	logic [lsu_pkg::WORD_W-1:0]   ea;
	logic                         accept;

	function automatic logic [lsu_pkg::WORD_W-1:0] offset_apply(
		input logic [lsu_pkg::WORD_W-1:0] base,
		input logic                       add,
		input logic [lsu_pkg::IMM_W-1:0]  imm
	);
		logic [lsu_pkg::WORD_W-1:0] wide;
		wide = {{(lsu_pkg::WORD_W-lsu_pkg::IMM_W){1'b0}}, imm};
		return add ? base + wide : base - wide;
	endfunction

	function automatic logic imm_legal(
		input lsu_pkg::xfer_kind_t kind,
		input lsu_pkg::xfer_size_t size,
		input logic                sgn,
		input lsu_pkg::addr_mode_t mode,
		input logic                add,
		input logic [lsu_pkg::IMM_W-1:0] imm
	);
		logic ok;
		ok = 1'b1;
		if (kind == lsu_pkg::KIND_NONE) begin
			ok = 1'b0;
		end else if (kind == lsu_pkg::KIND_ADR) begin
			ok = (imm <= lsu_pkg::IMM_MAX_WIDE);
		end else if (sgn && (kind == lsu_pkg::KIND_STORE || size == lsu_pkg::SIZE_PAIR)) begin
			ok = 1'b0;
		end else if (size == lsu_pkg::SIZE_PAIR) begin
			ok = (mode != lsu_pkg::MODE_REG) && (imm <= lsu_pkg::IMM_MAX_PAIR) && (imm[1:0] == 2'b00);
		end else if (mode == lsu_pkg::MODE_OFFSET) begin
			ok = add || (imm <= lsu_pkg::IMM_MAX_INDEX);
		end else if (mode != lsu_pkg::MODE_REG) begin
			ok = (imm <= lsu_pkg::IMM_MAX_INDEX);
		end
		return ok;
	endfunction

	function automatic logic [3:0] lane_be(input lsu_pkg::xfer_size_t size, input logic [1:0] lo);
		logic [3:0] be;
		case (size)
			lsu_pkg::SIZE_BYTE: be = 4'h1 << lo;
			lsu_pkg::SIZE_HALF: be = lo[1] ? 4'hC : 4'h3;
			default:            be = 4'hF;
		endcase
		return be;
	endfunction

	function automatic logic [lsu_pkg::WORD_W-1:0] lane_data(
		input lsu_pkg::xfer_size_t        size,
		input logic [lsu_pkg::WORD_W-1:0] d
	);
		logic [lsu_pkg::WORD_W-1:0] w;
		case (size)
			lsu_pkg::SIZE_BYTE: w = {4{d[7:0]}};
			lsu_pkg::SIZE_HALF: w = {2{d[15:0]}};
			default:            w = d;
		endcase
		return w;
	endfunction

	load_extend u_extend (
		.addr_lo (s_r.mem_addr[1:0]),
		.size    (s_r.size),
		.sgn     (s_r.sgn),
		.rdata   (mem_rdata),
		.data    (ext_data)
	);

	assign accept = req_valid && req_ready;

	always_comb begin
		s_nxt          = s_r;
		s_nxt.rf_we    = 1'b0;
		s_nxt.wb_we    = 1'b0;
		s_nxt.br_valid = 1'b0;
		s_nxt.done     = 1'b0;
		s_nxt.fault    = 1'b0;
		imm_sum        = offset_apply(req_base, req_add, req_imm);
		ea             = '0;
		case (s_r.st)
			lsu_pkg::ST_IDLE: begin
				if (req_valid) begin
					s_nxt.kind   = req_kind;
					s_nxt.size   = req_size;
					s_nxt.sgn    = req_signed;
					s_nxt.mode   = req_mode;
					s_nxt.rt     = req_rt;
					s_nxt.rt2    = req_rt2;
					s_nxt.rn     = req_rn;
					s_nxt.data2  = req_st_data2;
					s_nxt.wb_val = imm_sum;
					s_nxt.second = 1'b0;
					if (!req_cond_pass) begin
						s_nxt.done = 1'b1;
					end else if (!imm_legal(req_kind, req_size, req_signed, req_mode, req_add, req_imm)) begin
						s_nxt.fault = 1'b1;
						s_nxt.done  = 1'b1;
					end else if (req_kind == lsu_pkg::KIND_ADR) begin
						s_nxt.rf_we    = 1'b1;
						s_nxt.rf_waddr = req_rt;
						s_nxt.rf_wdata = offset_apply(req_pc, req_add, req_imm);
						s_nxt.done     = 1'b1;
					end else begin
						case (req_mode)
							lsu_pkg::MODE_REG:  ea = req_base + (req_index << req_shift);
							lsu_pkg::MODE_POST: ea = req_base;
							default:            ea = imm_sum;
						endcase
						s_nxt.st        = lsu_pkg::ST_ACCESS;
						s_nxt.mem_req   = 1'b1;
						s_nxt.mem_we    = (req_kind == lsu_pkg::KIND_STORE);
						s_nxt.mem_addr  = ea;
						s_nxt.mem_be    = lane_be(req_size, ea[1:0]);
						s_nxt.mem_wdata = lane_data(req_size, req_st_data);
					end
				end
			end
			lsu_pkg::ST_ACCESS: begin
				if (mem_ack) begin
					s_nxt.mem_req = 1'b0;
					if (s_r.kind == lsu_pkg::KIND_LOAD) begin
						if (s_r.size == lsu_pkg::SIZE_WORD && s_r.rt == lsu_pkg::PC_IDX) begin
							s_nxt.br_valid  = 1'b1;
							s_nxt.br_target = mem_rdata & lsu_pkg::BIT0_CLEAR;
						end else begin
							s_nxt.rf_we    = 1'b1;
							s_nxt.rf_waddr = s_r.second ? s_r.rt2 : s_r.rt;
							s_nxt.rf_wdata = ext_data;
						end
					end
					if (s_r.size == lsu_pkg::SIZE_PAIR && !s_r.second) begin
						s_nxt.second    = 1'b1;
						s_nxt.mem_req   = 1'b1;
						s_nxt.mem_addr  = s_r.mem_addr + lsu_pkg::PAIR_STEP;
						s_nxt.mem_wdata = s_r.data2;
					end else begin
						s_nxt.st   = lsu_pkg::ST_IDLE;
						s_nxt.done = 1'b1;
						if (s_r.mode == lsu_pkg::MODE_PRE || s_r.mode == lsu_pkg::MODE_POST) begin
							s_nxt.wb_we   = 1'b1;
							s_nxt.wb_addr = s_r.rn;
							s_nxt.wb_data = s_r.wb_val;
						end
					end
				end
			end
			default: begin
				s_nxt = lsu_pkg::LSU_RESET;
			end
		endcase
	end

	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			s_r <= lsu_pkg::LSU_RESET;
		end else begin
			s_r <= s_nxt;
		end
	end

	assign req_ready     = (s_r.st == lsu_pkg::ST_IDLE);
	assign mem_req       = s_r.mem_req;
	assign mem_we        = s_r.mem_we;
	assign mem_addr      = s_r.mem_addr;
	assign mem_be        = s_r.mem_be;
	assign mem_wdata     = s_r.mem_wdata;
	assign rf_we         = s_r.rf_we;
	assign rf_waddr      = s_r.rf_waddr;
	assign rf_wdata      = s_r.rf_wdata;
	assign wb_we         = s_r.wb_we;
	assign wb_addr       = s_r.wb_addr;
	assign wb_data       = s_r.wb_data;
	assign branch_valid  = s_r.br_valid;
	assign branch_target = s_r.br_target;
	assign flags_we      = 1'b0;
	assign done          = s_r.done;
	assign fault         = s_r.fault;

	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!rst_n);

	sequence s_legal_go;
		accept && req_cond_pass && imm_legal(req_kind, req_size, req_signed, req_mode, req_add, req_imm);
	endsequence

	sequence s_signed_byte_ack;
		s_r.st == lsu_pkg::ST_ACCESS && mem_ack && !mem_we && s_r.size == lsu_pkg::SIZE_BYTE && s_r.sgn;
	endsequence

	AST_ADR_SUM: assert property (s_legal_go ##0 (req_kind == lsu_pkg::KIND_ADR) |=>
		rf_we && done && rf_wdata == ($past(req_add) ? $past(req_pc) + 32'($past(req_imm))
		                                             : $past(req_pc) - 32'($past(req_imm))))
		else $error("address result is not pc plus immediate");

	AST_INDEX_RANGE: assert property (accept && req_cond_pass && req_kind == lsu_pkg::KIND_LOAD
		&& req_size == lsu_pkg::SIZE_WORD && req_mode == lsu_pkg::MODE_PRE && req_imm > 12'h0FF
		|=> fault && done && !mem_req)
		else $error("out of range pre-index immediate was not refused");

	AST_COND_FAIL: assert property (accept && !req_cond_pass |=>
		done && !rf_we && !mem_req && !wb_we && !fault && !branch_valid)
		else $error("failed condition caused an effect");

	AST_POST_ADDR: assert property (s_legal_go ##0 (req_kind != lsu_pkg::KIND_ADR
		&& req_mode == lsu_pkg::MODE_POST) |=> mem_req && mem_addr == $past(req_base))
		else $error("post-index access not at base");

	AST_REG_ADDR: assert property (s_legal_go ##0 (req_kind != lsu_pkg::KIND_ADR
		&& req_mode == lsu_pkg::MODE_REG) |=> mem_addr == $past(req_base) + ($past(req_index) << $past(req_shift)))
		else $error("register offset address wrong");

	AST_PAIR_STEP: assert property (s_r.st == lsu_pkg::ST_ACCESS && mem_ack
		&& s_r.size == lsu_pkg::SIZE_PAIR && !s_r.second |=> mem_req && mem_addr == $past(mem_addr) + 32'h0000_0004)
		else $error("pair second word not four bytes above first");

	AST_PC_LOAD: assert property (s_r.st == lsu_pkg::ST_ACCESS && mem_ack && !mem_we
		&& s_r.size == lsu_pkg::SIZE_WORD && s_r.rt == lsu_pkg::PC_IDX
		|=> branch_valid && !rf_we && branch_target == ($past(mem_rdata) & 32'hFFFF_FFFE))
		else $error("pc load did not branch with bit0 cleared");

	AST_SIGN_BYTE: assert property (s_signed_byte_ack |=> rf_we && rf_wdata[31:8] == {24{rf_wdata[7]}})
		else $error("signed byte load not sign extended");

	AST_NO_WB: assert property (done && (s_r.mode == lsu_pkg::MODE_REG || s_r.mode == lsu_pkg::MODE_OFFSET)
		|-> !wb_we)
		else $error("base written back in a mode without write-back");

	AST_NO_FLAGS: assert property (mem_req |-> !flags_we)
		else $error("flags written during a transfer");

endmodule

`default_nettype wire

/* sim/data_mem_model.sv */
// Data memory model on the far side of the load/store address unit.
// Assumes one clock; answers each request after lag cycles with a one-cycle ack.
`default_nettype none

module data_mem_model (
	input  wire logic        sys_clk,
	input  wire logic        rst_n,
	input  wire logic        mem_req,
	input  wire logic        mem_we,
	input  wire logic [31:0] mem_addr,
	input  wire logic [3:0]  mem_be,
	input  wire logic [31:0] mem_wdata,
	input  wire logic [3:0]  lag,
	output logic      [31:0] mem_rdata,
	output logic             mem_ack
);
	timeunit 1ns;
	timeprecision 1ps;

	logic [31:0] store_r [16];
	logic [3:0]  wait_r;
	logic [31:0] last_r;

	assign mem_ack = mem_req && (wait_r == lag);
	// Outside the ack cycle the read bus carries no stale copy of the last word
	assign mem_rdata = mem_ack ? store_r[mem_addr[5:2]] : ~last_r;

	always @(posedge sys_clk) begin
		if (!rst_n) begin
			wait_r <= 4'h0;
			last_r <= 32'h0;
			for (int i = 0; i < 16; i++) store_r[i] <= 32'h80FF7F01;
		end else if (mem_ack) begin
			wait_r <= 4'h0;
			last_r <= mem_rdata;
			for (int b = 0; b < 4; b++) begin
				if (mem_we && mem_be[b]) store_r[mem_addr[5:2]][b*8 +: 8] <= mem_wdata[b*8 +: 8];
			end
		end else if (mem_req) begin
			wait_r <= wait_r + 4'h1;
		end
	end
endmodule

`default_nettype wire

/* sim/load_store_address_unit_bench.sv */
// Self-checking bench for the load/store address unit against a data memory model.
// Assumes the package is compiled first; inputs change on the falling clock edge.
`default_nettype none

module load_store_address_unit_bench;
	timeunit 1ns;
	timeprecision 1ps;

	localparam lsu_pkg::xfer_kind_t AD = lsu_pkg::KIND_ADR;
	localparam lsu_pkg::xfer_kind_t LD = lsu_pkg::KIND_LOAD;
	localparam lsu_pkg::xfer_kind_t ST = lsu_pkg::KIND_STORE;
	localparam lsu_pkg::xfer_kind_t NO = lsu_pkg::KIND_NONE;
	localparam lsu_pkg::xfer_size_t BY = lsu_pkg::SIZE_BYTE;
	localparam lsu_pkg::xfer_size_t HW = lsu_pkg::SIZE_HALF;
	localparam lsu_pkg::xfer_size_t WD = lsu_pkg::SIZE_WORD;
	localparam lsu_pkg::xfer_size_t PA = lsu_pkg::SIZE_PAIR;
	localparam lsu_pkg::addr_mode_t OF = lsu_pkg::MODE_OFFSET;
	localparam lsu_pkg::addr_mode_t PR = lsu_pkg::MODE_PRE;
	localparam lsu_pkg::addr_mode_t PO = lsu_pkg::MODE_POST;
	localparam lsu_pkg::addr_mode_t RG = lsu_pkg::MODE_REG;
	localparam logic [31:0] ST_D = 32'h12345678;
	localparam logic [31:0] ST_D2 = 32'h9ABCDEF0;

	// f holds {signed, add, expect fault, expect write-back}
	typedef struct packed {
		lsu_pkg::xfer_kind_t k;
		lsu_pkg::xfer_size_t s;
		lsu_pkg::addr_mode_t m;
		logic [3:0]          f;
		logic [11:0]         imm;
		logic [1:0]          sh;
		logic [31:0]         base;
		logic [3:0]          ix;
		logic [3:0]          rt;
		logic [1:0]          n;
		logic [31:0]         ea;
		logic [3:0]          be;
		logic [31:0]         ed;
		logic [31:0]         ewb;
	} row_t;

	row_t rows [22] = '{
		'{AD,WD,OF,4'h4,12'hFFF,2'h0,32'h2000,4'h0,4'h3,2'h0,32'h0,4'h0,32'h2FFF,32'h0},
		'{AD,WD,OF,4'h0,12'hFFF,2'h0,32'h2000,4'h0,4'h3,2'h0,32'h0,4'h0,32'h1001,32'h0},
		'{LD,WD,OF,4'h4,12'h010,2'h0,32'h1000,4'h0,4'h3,2'h1,32'h1010,4'hF,32'h80FF7F01,32'h0},
		'{LD,BY,PR,4'h1,12'h0FF,2'h0,32'h1102,4'h0,4'h3,2'h1,32'h1003,4'h8,32'h80,32'h1003},
		'{LD,BY,PO,4'hD,12'h0FF,2'h0,32'h1003,4'h0,4'h3,2'h1,32'h1003,4'h8,32'hFFFFFF80,32'h1102},
		'{LD,HW,OF,4'hC,12'h002,2'h0,32'h1000,4'h0,4'h3,2'h1,32'h1002,4'hC,32'hFFFF80FF,32'h0},
		'{LD,HW,RG,4'h0,12'h000,2'h3,32'h1000,4'h4,4'h3,2'h1,32'h1020,4'h3,32'h7F01,32'h0},
		'{LD,BY,RG,4'h0,12'h000,2'h0,32'h1000,4'h2,4'h3,2'h1,32'h1002,4'h4,32'hFF,32'h0},
		'{ST,BY,OF,4'h4,12'h021,2'h0,32'h1000,4'h0,4'h3,2'h1,32'h1021,4'h2,32'h78787878,32'h0},
		'{ST,HW,PO,4'h1,12'h008,2'h0,32'h1032,4'h0,4'h3,2'h1,32'h1032,4'hC,32'h56785678,32'h102A},
		'{ST,WD,RG,4'h0,12'h000,2'h2,32'h1030,4'h1,4'h3,2'h1,32'h1034,4'hF,ST_D,32'h0},
		'{ST,BY,OF,4'hE,12'h004,2'h0,32'h1000,4'h0,4'h3,2'h0,32'h0,4'h0,32'h0,32'h0},
		'{LD,WD,PR,4'h6,12'h100,2'h0,32'h1000,4'h0,4'h3,2'h0,32'h0,4'h0,32'h0,32'h0},
		'{LD,WD,OF,4'h2,12'h100,2'h0,32'h1000,4'h0,4'h3,2'h0,32'h0,4'h0,32'h0,32'h0},
		'{LD,WD,OF,4'h4,12'hFFF,2'h0,32'h1001,4'h0,4'h3,2'h1,32'h2000,4'hF,32'h80FF7F01,32'h0},
		'{LD,PA,PR,4'h6,12'h3FD,2'h0,32'h1000,4'h0,4'h3,2'h0,32'h0,4'h0,32'h0,32'h0},
		'{LD,PA,OF,4'h6,12'h400,2'h0,32'h1000,4'h0,4'h3,2'h0,32'h0,4'h0,32'h0,32'h0},
		'{LD,PA,RG,4'h6,12'h000,2'h0,32'h1000,4'h0,4'h3,2'h0,32'h0,4'h0,32'h0,32'h0},
		'{NO,WD,OF,4'h6,12'h000,2'h0,32'h1000,4'h0,4'h3,2'h0,32'h0,4'h0,32'h0,32'h0},
		'{LD,PA,PR,4'h5,12'h3FC,2'h0,32'h0C04,4'h0,4'h3,2'h2,32'h1000,4'hF,32'h80FF7F01,32'h1000},
		'{ST,PA,PO,4'h1,12'h3FC,2'h0,32'h1038,4'h0,4'h3,2'h2,32'h1038,4'hF,ST_D,32'h0C3C},
		'{LD,WD,OF,4'h4,12'h000,2'h0,32'h1010,4'h0,4'hF,2'h1,32'h1010,4'hF,32'h80FF7F00,32'h0}};

	logic                sys_clk, rst_n, req_valid, req_ready, req_signed, req_add, req_cond_pass;
	logic                mem_req, mem_we, mem_ack, rf_we, wb_we, branch_valid, flags_we, done, fault;
	lsu_pkg::xfer_kind_t req_kind;
	lsu_pkg::xfer_size_t req_size;
	lsu_pkg::addr_mode_t req_mode;
	logic [11:0]         req_imm;
	logic [1:0]          req_shift;
	logic [3:0]          req_rt, req_rt2, req_rn, rf_waddr, wb_addr, mem_be, lag;
	logic [31:0]         req_base, req_index, req_pc, req_st_data, req_st_data2, mem_addr, mem_wdata;
	logic [31:0]         mem_rdata, rf_wdata, wb_data, branch_target, wbd, brt;
	logic [31:0]         aa [4], aw [4], rd [4];
	logic [3:0]          ab [4], ra [4];
	logic                wbs, brs, flt, dn;
	int                  n, nrf, nwe, checks, miscompares;

	assign req_rt2 = 4'h5;
	assign req_rn = 4'h6;
	assign req_st_data = ST_D;
	assign req_st_data2 = ST_D2;

	load_store_address_unit u_load_store_address_unit (.sys_clk, .rst_n, .req_valid, .req_ready, .req_kind,
		.req_size, .req_signed, .req_mode, .req_add, .req_imm, .req_shift, .req_base, .req_index, .req_pc,
		.req_cond_pass, .req_rt, .req_rt2, .req_rn, .req_st_data, .req_st_data2, .mem_req, .mem_we, .mem_addr,
		.mem_be, .mem_wdata, .mem_rdata, .mem_ack, .rf_we, .rf_waddr, .rf_wdata, .wb_we, .wb_addr, .wb_data,
		.branch_valid, .branch_target, .flags_we, .done, .fault);

	data_mem_model u_data_mem_model (.sys_clk, .rst_n, .mem_req, .mem_we, .mem_addr, .mem_be, .mem_wdata, .lag,
		.mem_rdata, .mem_ack);

	always #4 sys_clk = ~sys_clk;

	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		checks++;
		if (g !== e) begin
			miscompares++;
			$display("MISMATCH %s expected %h seen %h", nm, e, g);
		end
	endtask

	task automatic set_req(input row_t r, input logic c);
		req_kind = r.k;
		req_size = r.s;
		req_mode = r.m;
		{req_signed, req_add} = r.f[3:2];
		req_imm = r.imm;
		req_shift = r.sh;
		req_base = r.base;
		req_pc = r.base;
		req_index = 32'(r.ix);
		req_rt = r.rt;
		req_cond_pass = c;
	endtask

	task automatic launch(input row_t r, input logic c);
		@(negedge sys_clk);
		set_req(r, c);
		req_valid = 1'h1;
	endtask

	// Runs one instruction and logs accesses and register writes until done
	task automatic run(input row_t r, input logic c);
		launch(r, c);
		n = 0;
		nrf = 0;
		nwe = 0;
		{wbs, brs, flt, dn} = 4'h0;
		for (int i = 0; i < 40 && !dn; i++) begin
			@(negedge sys_clk);
			req_valid = 1'h0;
			chk("flags_we", 32'h0, 32'(flags_we));
			if (mem_req === 1'h1 && mem_ack === 1'h1 && n < 4) begin
				{aa[n], ab[n], aw[n]} = {mem_addr, mem_be, mem_wdata};
				if (mem_we === 1'h1) nwe++;
				n++;
			end
			if (rf_we === 1'h1 && nrf < 4) begin
				{rd[nrf], ra[nrf]} = {rf_wdata, rf_waddr};
				nrf++;
			end
			if (wb_we === 1'h1) {wbs, wbd} = {1'h1, wb_data};
			if (branch_valid === 1'h1) {brs, brt} = {1'h1, branch_target};
			if (fault === 1'h1) flt = 1'h1;
			dn = (done === 1'h1);
		end
		chk("done", 32'h1, 32'(dn));
	endtask

	task automatic check_row(input row_t r);
		logic br;
		int   en;
		br = r.k == LD && r.s == WD && r.rt == lsu_pkg::PC_IDX;
		en = (r.f[1] || r.k == ST || br) ? 0 : ((r.s == PA) ? 2 : 1);
		chk("fault", 32'(r.f[1]), 32'(flt));
		chk("accesses", 32'(r.n), 32'(n));
		chk("mem_writes", (r.k == ST) ? 32'(r.n) : 32'h0, 32'(nwe));
		chk("rf_writes", 32'(en), 32'(nrf));
		chk("branch", 32'(br), 32'(brs));
		chk("writeback", 32'(r.f[0]), 32'(wbs));
		if (r.f[0]) chk("wb_data", r.ewb, wbd);
		if (r.f[0]) chk("wb_addr", 32'h6, 32'(wb_addr));
		if (r.n != 2'h0) chk("addr", r.ea, aa[0]);
		if (r.n != 2'h0) chk("be", 32'(r.be), 32'(ab[0]));
		if (!r.f[1]) chk("data", r.ed, r.k == ST ? aw[0] : (br ? brt : rd[0]));
		if (en != 0) chk("rf_addr", 32'(r.rt), 32'(ra[0]));
		if (en == 2) chk("rf_addr2", 32'h5, 32'(ra[1]));
		if (r.n == 2'h2) chk("addr2", r.ea + 32'h4, aa[1]);
		if (r.n == 2'h2) chk("data2", r.k == ST ? ST_D2 : r.ed, r.k == ST ? aw[1] : rd[1]);
	endtask

	task automatic check_idle;
		chk("idle_outputs", 32'h40, 32'({req_ready, mem_req, rf_we, wb_we, branch_valid, done, fault}));
	endtask

	task automatic stop_test;
		$display("checks %0d miscompares %0d", checks, miscompares);
		if (miscompares == 0 && checks > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask

	initial begin
		{sys_clk, rst_n, req_valid} = 3'h0;
		lag = 4'h0;
		set_req(rows[0], 1'h1);
		repeat (8) @(negedge sys_clk);
		check_idle;
		rst_n = 1'h1;
		// Every row passes its condition, so no conditional pc load is left mid-block
		foreach (rows[i]) begin
			run(rows[i], 1'h1);
			check_row(rows[i]);
		end
		// Failed condition on a pre-indexed load
		run(rows[3], 1'h0);
		chk("cond_access", 32'h0, 32'(n));
		chk("cond_rf", 32'h0, 32'(nrf));
		chk("cond_wb", 32'h0, 32'(wbs));
		chk("cond_fault", 32'h0, 32'(flt));
		chk("cond_branch", 32'h0, 32'(brs));
		// Paired load against a slow memory
		lag = 4'h3;
		run(rows[19], 1'h1);
		check_row(rows[19]);
		// Reset while an access is still waiting for its ack
		lag = 4'h8;
		launch(rows[2], 1'h1);
		@(negedge sys_clk);
		req_valid = 1'h0;
		repeat (2) @(negedge sys_clk);
		chk("req_pending", 32'h1, 32'(mem_req));
		chk("ready_pending", 32'h0, 32'(req_ready));
		rst_n = 1'h0;
		repeat (2) @(negedge sys_clk);
		check_idle;
		rst_n = 1'h1;
		lag = 4'h0;
		run(rows[0], 1'h1);
		check_row(rows[0]);
		stop_test;
	end

	// About 26 instructions of under 50 cycles each; 3000 cycles means a hang
	initial begin
		repeat (3000) @(posedge sys_clk);
		miscompares++;
		stop_test;
	end
endmodule

`default_nettype wire
